//--- hdl/cmvt_pkg.sv
// Purpose: constants for the MSI, product-data and timer override register slice
// Assumes: AXI4-Lite slave, 32-bit data, byte offsets as printed
// Notes: interrupt status and mask words sit above the timer word, past the unmapped offset 0x74
package cmvt_pkg;
  localparam logic [7:0]  OFS_MSI_UPPER   = 8'h54;
  localparam logic [7:0]  OFS_MSI_PAYLOAD = 8'h58;
  localparam logic [7:0]  OFS_PD_CAP      = 8'h5C;
  localparam logic [7:0]  OFS_PD_WORD     = 8'h60;
  localparam logic [7:0]  OFS_VEND_CAP    = 8'h64;
  localparam logic [7:0]  OFS_TEST_ZERO   = 8'h68;
  localparam logic [7:0]  OFS_TEST_ONE    = 8'h6C;
  localparam logic [7:0]  OFS_TIMERS      = 8'h70;
  localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h78;
  localparam logic [7:0]  OFS_IRQ_MASK    = 8'h7C;
  localparam logic [7:0]  PD_CAP_ID       = 8'h03;
  localparam logic [7:0]  PD_NEXT_PTR     = 8'h64;
  localparam logic [7:0]  VEND_CAP_ID     = 8'h09;
  localparam logic [7:0]  VEND_NEXT_PTR   = 8'hB0;
  localparam logic [15:0] VEND_LENGTH     = 16'h0034;
  localparam logic [31:0] TEST_ZERO_RST   = 32'h04001060;
  localparam logic [31:0] TEST_ONE_RST    = 32'h04000800;
  localparam int          PD_ADDR_LSB     = 18;
  localparam int          PD_ADDR_MSB     = 23;
  localparam int          PD_FLAG_BIT     = 31;
  localparam int          RPL_EN_BIT      = 12;
  localparam int          ACK_LSB         = 16;
  localparam int          ACK_MSB         = 29;
  localparam int          ACK_EN_BIT      = 30;
  localparam int          VGA_BIT         = 31;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
  localparam int          IRQ_W           = 2;
  localparam int          IRQ_RD_DONE     = 0;
  localparam int          IRQ_WR_DONE     = 1;
  typedef enum logic [1:0] {
    PD_IDLE = 2'b00,
    PD_READ = 2'b01,
    PD_WRIT = 2'b10
  } cmvt_pd_e;
endpackage : cmvt_pkg

//--- hdl/cmvt_regs.sv
// Purpose: configuration registers for MSI, product-data access and link timer overrides
// Assumes: AXI4-Lite slave; external table engine answers with a one-cycle done pulse
// Notes: one write and one read in flight at most
module cmvt_regs
  import cmvt_pkg::*;
#(
  parameter int                 ADDR_W      = 8,
  parameter logic [11:0]        RPL_DEFAULT = 12'h0C0,
  parameter logic [13:0]        ACK_DEFAULT = 14'h0040
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // AXI4-Lite write address, data and response
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Table engine
  output logic                   tbl_rd_req,
  output logic                   tbl_wr_req,
  output logic [5:0]             tbl_addr,
  output logic [31:0]            tbl_wdata,
  input  wire logic              tbl_done,
  input  wire logic [31:0]       tbl_rdata,
  // Link timers and status
  input  wire logic              msi_addr64_cap,
  output logic [63:0]            msi_address_hi,
  output logic [15:0]            msi_payload,
  output logic [11:0]            replay_limit,
  output logic [13:0]            ack_latency,
  output logic [31:0]            test_zero,
  output logic [31:0]            test_one,
  output logic                   irq
);

  logic [31:0]       msi_upper_q;
  logic [15:0]       msi_data_q;
  logic [5:0]        pd_addr_q;
  logic              pd_flag_q;
  logic [31:0]       pd_word_q;
  logic [31:0]       tz_q;
  logic [31:0]       to_q;
  logic [11:0]       rpl_q;
  logic              rpl_en_q;
  logic [13:0]       ack_q;
  logic              ack_en_q;
  logic [IRQ_W-1:0]  sts_q;
  logic [IRQ_W-1:0]  msk_q;
  cmvt_pd_e          pd_q;

  logic              aw_hold_q;
  logic              w_hold_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              do_write;
  logic [7:0]        wa;
  logic [7:0]        ra;
  logic [31:0]       wmask;
  logic [31:0]       rd_d;
  logic              rd_hit;
  logic              wr_hit;
  logic [IRQ_W-1:0]  ev;

  // Write channel capture, address and data taken in either order
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_hold_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready  <= !w_hold_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  assign do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign wa       = 8'(awaddr_q);
  assign ra       = 8'(s_axi_araddr);

  // Byte lanes to bit mask
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign wmask[gi*8 +: 8] = {8{wstrb_q[gi]}};
    end
  endgenerate

  always_comb begin
    wr_hit = (wa[1:0] == 2'h0) && (wa >= OFS_MSI_UPPER) && (wa <= OFS_TIMERS ||
             wa == OFS_IRQ_STATUS || wa == OFS_IRQ_MASK);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // MSI words
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      msi_upper_q <= '0;
      msi_data_q  <= '0;
    end else if (do_write) begin
      if (wa == OFS_MSI_UPPER)
        msi_upper_q <= (wdata_q & wmask) | (msi_upper_q & ~wmask);
      if (wa == OFS_MSI_PAYLOAD)
        msi_data_q <= (wdata_q[15:0] & wmask[15:0]) | (msi_data_q & ~wmask[15:0]);
    end
  end

  // Upper address applies only with 64-bit capability
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      msi_address_hi <= '0;
      msi_payload    <= '0;
    end else begin
      msi_address_hi <= {(msi_addr64_cap ? msi_upper_q : 32'h00000000), 32'h00000000};
      msi_payload    <= msi_data_q;
    end
  end

  // Product-data address, flag and sequencer
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pd_addr_q  <= '0;
      pd_flag_q  <= 1'b0;
      pd_q       <= PD_IDLE;
      tbl_rd_req <= 1'b0;
      tbl_wr_req <= 1'b0;
    end else begin
      tbl_rd_req <= 1'b0;
      tbl_wr_req <= 1'b0;
      unique case (pd_q)
        PD_IDLE: begin
          if (do_write && wa == OFS_PD_CAP && wstrb_q[3]) begin
            if (wstrb_q[2])
              pd_addr_q <= wdata_q[PD_ADDR_MSB:PD_ADDR_LSB];
            pd_flag_q <= wdata_q[PD_FLAG_BIT];
            if (wdata_q[PD_FLAG_BIT]) begin
              pd_q       <= PD_WRIT;
              tbl_wr_req <= 1'b1;
            end else begin
              pd_q       <= PD_READ;
              tbl_rd_req <= 1'b1;
            end
          end else if (do_write && wa == OFS_PD_CAP && wstrb_q[2]) begin
            pd_addr_q <= wdata_q[PD_ADDR_MSB:PD_ADDR_LSB];
          end
        end
        PD_READ: if (tbl_done) begin
          pd_flag_q <= 1'b1;
          pd_q      <= PD_IDLE;
        end
        PD_WRIT: if (tbl_done) begin
          pd_flag_q <= 1'b0;
          pd_q      <= PD_IDLE;
        end
        default: pd_q <= PD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tbl_addr  <= '0;
      tbl_wdata <= '0;
    end else begin
      tbl_addr  <= pd_addr_q;
      tbl_wdata <= pd_word_q;
    end
  end

  // Data word: software write, or fetched data on read completion
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pd_word_q <= '0;
    end else if (pd_q == PD_READ && tbl_done) begin
      pd_word_q <= tbl_rdata;
    end else if (do_write && wa == OFS_PD_WORD) begin
      pd_word_q <= (wdata_q & wmask) | (pd_word_q & ~wmask);
    end
  end

  // Test registers and timer overrides
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tz_q     <= TEST_ZERO_RST;
      to_q     <= TEST_ONE_RST;
      rpl_q    <= '0;
      rpl_en_q <= 1'b0;
      ack_q    <= '0;
      ack_en_q <= 1'b0;
    end else if (do_write) begin
      if (wa == OFS_TEST_ZERO)
        tz_q <= (wdata_q & wmask) | (tz_q & ~wmask);
      if (wa == OFS_TEST_ONE)
        to_q <= (wdata_q & wmask) | (to_q & ~wmask);
      if (wa == OFS_TIMERS) begin
        if (wstrb_q[0])
          rpl_q[7:0] <= wdata_q[7:0];
        if (wstrb_q[1]) begin
          rpl_q[11:8] <= wdata_q[11:8];
          rpl_en_q    <= wdata_q[RPL_EN_BIT];
        end
        if (wstrb_q[2])
          ack_q[7:0] <= wdata_q[ACK_LSB +: 8];
        if (wstrb_q[3]) begin
          ack_q[13:8] <= wdata_q[ACK_MSB:ACK_LSB+8];
          ack_en_q    <= wdata_q[ACK_EN_BIT];
        end
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      replay_limit <= RPL_DEFAULT;
      ack_latency  <= ACK_DEFAULT;
      test_zero    <= TEST_ZERO_RST;
      test_one     <= TEST_ONE_RST;
    end else begin
      replay_limit <= rpl_en_q ? rpl_q : RPL_DEFAULT;
      ack_latency  <= ack_en_q ? ack_q : ACK_DEFAULT;
      test_zero    <= tz_q;
      test_one     <= to_q;
    end
  end

  // Completion events, write-one-to-clear; set wins over clear
  assign ev[IRQ_RD_DONE] = (pd_q == PD_READ) && tbl_done;
  assign ev[IRQ_WR_DONE] = (pd_q == PD_WRIT) && tbl_done;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sts_q <= '0;
      msk_q <= '0;
      irq   <= 1'b0;
    end else begin
      if (do_write && wa == OFS_IRQ_STATUS && wstrb_q[0])
        sts_q <= (sts_q & ~wdata_q[IRQ_W-1:0]) | ev;
      else
        sts_q <= sts_q | ev;
      if (do_write && wa == OFS_IRQ_MASK && wstrb_q[0])
        msk_q <= wdata_q[IRQ_W-1:0];
      irq <= |(sts_q & msk_q);
    end
  end

  // Read path
  always_comb begin
    rd_d   = 32'h00000000;
    rd_hit = (ra[1:0] == 2'h0);
    unique case (ra)
      OFS_MSI_UPPER:   rd_d = msi_upper_q;
      OFS_MSI_PAYLOAD: rd_d = {16'h0000, msi_data_q};
      OFS_PD_CAP:      rd_d = {pd_flag_q, 7'h00, pd_addr_q, 2'h0, PD_NEXT_PTR, PD_CAP_ID};
      OFS_PD_WORD:     rd_d = pd_word_q;
      OFS_VEND_CAP:    rd_d = {VEND_LENGTH, VEND_NEXT_PTR, VEND_CAP_ID};
      OFS_TEST_ZERO:   rd_d = tz_q;
      OFS_TEST_ONE:    rd_d = to_q;
      OFS_TIMERS:      rd_d = {1'b1, ack_en_q, ack_q, 3'h0, rpl_en_q, rpl_q};
      OFS_IRQ_STATUS:  rd_d = {{(32-IRQ_W){1'b0}}, sts_q};
      OFS_IRQ_MASK:    rd_d = {{(32-IRQ_W){1'b0}}, msk_q};
      default:         rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_d;
        s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Checks
  chk_read_start: assert property (@(posedge clk_sys) disable iff (rst)
    (pd_q == PD_IDLE && do_write && wa == OFS_PD_CAP && wstrb_q[3] && !wdata_q[PD_FLAG_BIT])
    |=> (pd_q == PD_READ && !pd_flag_q && tbl_rd_req)) else $error("read start wrong");
  chk_read_done: assert property (@(posedge clk_sys) disable iff (rst)
    (pd_q == PD_READ && tbl_done) |=> (pd_flag_q && pd_q == PD_IDLE && pd_word_q == $past(tbl_rdata)))
    else $error("read completion wrong");
  chk_write_flag: assert property (@(posedge clk_sys) disable iff (rst)
    (pd_q == PD_WRIT) |-> pd_flag_q) else $error("write flag dropped early");
  chk_write_done: assert property (@(posedge clk_sys) disable iff (rst)
    (pd_q == PD_WRIT && tbl_done) |=> !pd_flag_q) else $error("write flag not cleared");
  chk_replay_sel: assert property (@(posedge clk_sys) disable iff (rst)
    ##1 replay_limit == ($past(rpl_en_q) ? $past(rpl_q) : RPL_DEFAULT)) else $error("replay limit");
  chk_ack_sel: assert property (@(posedge clk_sys) disable iff (rst)
    !ack_en_q [*2] |-> ack_latency == ACK_DEFAULT) else $error("ack latency override");
  chk_vend_read: assert property (@(posedge clk_sys) disable iff (rst)
    (s_axi_arvalid && s_axi_arready && ra == OFS_VEND_CAP)
    |=> s_axi_rdata == 32'h0034B009) else $error("vendor header wrong");
  chk_payload_hi: assert property (@(posedge clk_sys) disable iff (rst)
    (s_axi_arvalid && s_axi_arready && ra == OFS_MSI_PAYLOAD) |=> s_axi_rdata[31:16] == 16'h0000)
    else $error("payload upper bits");
  chk_vga_bit: assert property (@(posedge clk_sys) disable iff (rst)
    (s_axi_arvalid && s_axi_arready && ra == OFS_TIMERS) |=> s_axi_rdata[VGA_BIT])
    else $error("decode bit not set");
  chk_upper_cap: assert property (@(posedge clk_sys) disable iff (rst)
    !msi_addr64_cap |=> msi_address_hi == 64'h0) else $error("upper address leaked");
  // Table handoff and user timer value
  chk_tbl_addr: assert property (@(posedge clk_sys) disable iff (rst)
    (tbl_rd_req || tbl_wr_req) |=> tbl_addr == pd_addr_q)
    else $error("table address wrong");
  chk_tbl_wdata: assert property (@(posedge clk_sys) disable iff (rst)
    tbl_wr_req |=> tbl_wdata == $past(pd_word_q))
    else $error("table write data wrong");
  chk_ack_user: assert property (@(posedge clk_sys) disable iff (rst)
    ack_en_q |=> ack_latency == $past(ack_q))
    else $error("ack latency user value");
  cov_read: cover property (@(posedge clk_sys) disable iff (rst) pd_q == PD_READ ##[1:20] pd_flag_q);
  cov_write: cover property (@(posedge clk_sys) disable iff (rst) pd_q == PD_WRIT ##[1:20] !pd_flag_q);
  cov_irq: cover property (@(posedge clk_sys) disable iff (rst) irq);
  cov_override: cover property (@(posedge clk_sys) disable iff (rst) rpl_en_q && ack_en_q);
  cov_rd_then_wr: cover property (@(posedge clk_sys) disable iff (rst)
    ev[IRQ_RD_DONE] ##[1:200] ev[IRQ_WR_DONE]);

endmodule : cmvt_regs

//--- test/cmvt_regs_test.sv
// Purpose: self-checking bench for the MSI, product-data and timer register slice
// Assumes: bench plays AXI4-Lite master and table engine; model keeps writable bits only
// Notes: outputs lag the registers, so they are looked at two edges after a response
module cmvt_regs_test
  import cmvt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] RPL_DEFAULT = 12'h0C0;
  localparam logic [13:0] ACK_DEFAULT = 14'h0040;
  logic        clk_sys, rst;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, tbl_wdata, tbl_rdata, test_zero, test_one;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        tbl_rd_req, tbl_wr_req, tbl_done, msi_addr64_cap, irq;
  logic [5:0]  tbl_addr;
  logic [63:0] msi_address_hi;
  logic [15:0] msi_payload;
  logic [11:0] replay_limit;
  logic [13:0] ack_latency;
  logic [31:0] mdl [logic [7:0]];
  logic [7:0]  rw_ofs [6] = '{8'h54, 8'h58, 8'h64, 8'h68, 8'h6C, 8'h70};
  int          fail_count, checks, cyc, req_cnt;
  bit          req_wr;

  cmvt_regs #(.RPL_DEFAULT(RPL_DEFAULT), .ACK_DEFAULT(ACK_DEFAULT)) i_cmvt_regs (
    .clk_sys(clk_sys), .rst(rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .tbl_rd_req(tbl_rd_req), .tbl_wr_req(tbl_wr_req), .tbl_addr(tbl_addr),
    .tbl_wdata(tbl_wdata), .tbl_done(tbl_done), .tbl_rdata(tbl_rdata),
    .msi_addr64_cap(msi_addr64_cap), .msi_address_hi(msi_address_hi),
    .msi_payload(msi_payload), .replay_limit(replay_limit), .ack_latency(ack_latency),
    .test_zero(test_zero), .test_one(test_one), .irq(irq)
  );

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic print_verdict();
    if (fail_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Writable bits and fixed bits of each mapped word
  function automatic logic [31:0] wmask(input logic [7:0] a);
    case (a)
      8'h58:   return 32'h0000FFFF;
      8'h5C:   return 32'h80FC0000;
      8'h64:   return 32'h00000000;
      8'h70:   return 32'h7FFF1FFF;
      8'h78,
      8'h7C:   return 32'h00000003;
      default: return 32'hFFFFFFFF;
    endcase
  endfunction : wmask

  function automatic logic [31:0] fixed(input logic [7:0] a);
    case (a)
      8'h5C:   return 32'h00006403;
      8'h64:   return 32'h0034B009;
      8'h70:   return 32'h80000000;
      default: return 32'h00000000;
    endcase
  endfunction : fixed

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] bm;
    bit          aw_ok, w_ok;
    bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    @(posedge clk_sys);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    aw_ok = 0;
    w_ok  = 0;
    do begin
      @(posedge clk_sys);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(aw_ok && w_ok));
    do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check("bresp", {30'h0, s_axi_bresp}, mdl.exists(a) ? RESP_OKAY : RESP_SLVERR);
    if (a == 8'h78) mdl[a] = mdl[a] & ~(d & bm & wmask(a));
    else if (mdl.exists(a)) mdl[a] = (mdl[a] & ~(bm & wmask(a))) | (d & bm & wmask(a));
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a);
    @(posedge clk_sys);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge clk_sys);
    s_axi_rready <= 1'b0;
    check("rresp", {30'h0, s_axi_rresp}, mdl.exists(a) ? RESP_OKAY : RESP_SLVERR);
    check($sformatf("read %h", a), s_axi_rdata,
          mdl.exists(a) ? (mdl[a] | fixed(a)) : 32'h0);
  endtask : reg_rd

  task automatic chk_outs();
    logic [31:0] t;
    repeat (2) @(posedge clk_sys);
    t = mdl[8'h70];
    check("addr_hi", msi_address_hi[63:32], msi_addr64_cap ? mdl[8'h54] : 32'h0);
    check("addr_lo", msi_address_hi[31:0], 32'h0);
    check("payload", {16'h0, msi_payload}, mdl[8'h58]);
    check("test_zero", test_zero, mdl[8'h68]);
    check("test_one", test_one, mdl[8'h6C]);
    check("replay", {20'h0, replay_limit}, t[RPL_EN_BIT] ? t[11:0] : RPL_DEFAULT);
    check("ack", {18'h0, ack_latency},
          t[ACK_EN_BIT] ? t[ACK_MSB:ACK_LSB] : ACK_DEFAULT);
    check("irq", {31'h0, irq}, {31'h0, |(mdl[8'h78] & mdl[8'h7C])});
  endtask : chk_outs

  // Start pulses last one cycle; count them as the engine would
  always @(posedge clk_sys) begin
    if (tbl_rd_req === 1'b1 || tbl_wr_req === 1'b1) begin
      req_cnt++;
      req_wr = tbl_wr_req;
    end
  end

  // Engine side of one table cycle; software waits for completion
  task automatic tbl_cycle(input bit wr, input logic [31:0] d);
    while (req_cnt == 0) @(posedge clk_sys);
    check("req_count", req_cnt, 32'h1);
    check("rd_req", {31'h0, !req_wr}, {31'h0, !wr});
    req_cnt = 0;
    @(posedge clk_sys);
    check("tbl_addr", {26'h0, tbl_addr}, {26'h0, mdl[8'h5C][PD_ADDR_MSB:PD_ADDR_LSB]});
    if (wr) check("tbl_wdata", tbl_wdata, mdl[8'h60]);
    reg_rd(8'h5C);
    @(posedge clk_sys);
    tbl_done  <= 1'b1;
    tbl_rdata <= d;
    @(posedge clk_sys);
    tbl_done  <= 1'b0;
    tbl_rdata <= ~d;
    if (!wr) mdl[8'h60] = d;
    mdl[8'h5C][PD_FLAG_BIT] = !wr;
    mdl[8'h78][wr ? IRQ_WR_DONE : IRQ_RD_DONE] = 1'b1;
    reg_rd(8'h5C);
    reg_rd(8'h60);
  endtask : tbl_cycle

  initial begin
    logic [7:0] a;
    rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {tbl_done, tbl_rdata, msi_addr64_cap} = '0;
    foreach (rw_ofs[i]) mdl[rw_ofs[i]] = 32'h0;
    mdl[8'h5C] = 32'h0;
    mdl[8'h60] = 32'h0;
    mdl[8'h78] = 32'h0;
    mdl[8'h7C] = 32'h0;
    mdl[8'h68] = TEST_ZERO_RST;
    mdl[8'h6C] = TEST_ONE_RST;
    void'($urandom(32'h3e14));
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    chk_outs();
    foreach (mdl[k]) reg_rd(k);
    for (int i = 0; i < 16; i++) begin
      a = rw_ofs[$urandom_range(5)];
      msi_addr64_cap <= 1'($urandom);
      reg_wr(a, $urandom, (i < 8) ? 4'hF : 4'($urandom));
      reg_rd(a);
      chk_outs();
    end
    reg_wr(8'h7C, 32'h1, 4'hF);
    for (int k = 0; k < 4; k++) begin
      if (k[0]) reg_wr(8'h60, $urandom, 4'hF);
      reg_wr(8'h5C, {k[0], 7'h0, 6'($urandom), 18'h3FFFF}, 4'hF);
      tbl_cycle(k[0], $urandom);
      chk_outs();
    end
    reg_rd(8'h78);
    reg_wr(8'h78, 32'h1, 4'hF);
    chk_outs();
    reg_wr(8'h7C, 32'h3, 4'hF);
    chk_outs();
    reg_wr(8'h78, 32'hFFFFFFFF, 4'hF);
    chk_outs();
    reg_rd(8'h78);
    foreach (rw_ofs[i]) begin
      reg_wr(8'h74 + 8'(i * 4), 32'hFFFFFFFF, 4'hF);
      reg_rd(8'h55 + 8'(i * 8));
    end
    reg_rd(8'h64);
    chk_outs();
    check("stray_req", req_cnt, 32'h0);
    print_verdict();
  end
endmodule : cmvt_regs_test
